// ==== common/trap_status_map.svh ====
`ifndef TRAP_STATUS_MAP_SVH
`define TRAP_STATUS_MAP_SVH
// Register byte offsets on the AHB-Lite slave
`define TSC_OFF_CTRL 8'h00
`define TSC_OFF_IRQ_STAT 8'h04
`define TSC_OFF_IRQ_MASK 8'h08
// Bit positions inside trap_control_status
`define TSC_BIT_NEST_DIS 15
`define TSC_BIT_ACC_A_OVF 14
`define TSC_BIT_ACC_B_OVF 13
`define TSC_BIT_ACC_A_CAT 12
`define TSC_BIT_ACC_B_CAT 11
`define TSC_BIT_A_OVF_EN 10
`define TSC_BIT_B_OVF_EN 9
`define TSC_BIT_CAT_EN 8
`define TSC_BIT_SHIFT_ERR 7
`define TSC_BIT_DIV_ZERO 6
`define TSC_BIT_MATH_ERR 4
`define TSC_BIT_ADDR_ERR 3
`define TSC_BIT_STACK_ERR 2
`define TSC_BIT_OSC_FAIL 1
// Implemented bits: 5 and 0 read as zero
`define TSC_IMPL_MASK 16'hFFDE
// Flags that hardware sets (sticky)
`define TSC_FLAG_MASK 16'h78DE
`define TSC_RESET_VAL 16'h0000
`define TSC_IRQ_RESET_VAL 16'h0000
`endif

// ==== common/trap_status_pkg.sv ====
package trap_status_pkg;
    typedef logic [15:0] reg16_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } bus_phase_t;
endpackage

// ==== test/trap_cause_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Core side: raises the chosen trap causes one clock after fire, for as many clocks as fire stays high
module trap_cause_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic [9:0] sel,
    output logic [9:0] cause
);
    // Causes idle low; a one-cycle burst makes the flags prove they are sticky
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause <= 10'h000;
        end else begin
            cause <= fire ? sel : 10'h000;
        end
    end
endmodule
`default_nettype wire

// ==== test/trap_status_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "trap_status_map.svh"
module trap_status_control_tb;
    typedef struct packed {
        logic [15:0] en;
        logic [9:0] cause;
        logic [15:0] ctrl;
        logic [15:0] stat;
    } row_t;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic fire = 1'b0;
    logic [9:0] sel = 10'h000;
    logic [9:0] cause;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [5:0] traps;
    logic [31:0] rd;
    logic [3:0] exp_t;
    int error_cnt = 0;
    int checks_done = 0;
    row_t rows [14];

    trap_cause_model core (.clk(sys_clk), .rst_n(arst_n), .fire(fire), .sel(sel), .cause(cause));
    trap_status_control uut (.SYS_CLK(sys_clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .ACC_A_OVERFLOW(cause[9]),
        .ACC_B_OVERFLOW(cause[8]), .ACC_A_CATASTROPHIC(cause[7]), .ACC_B_CATASTROPHIC(cause[6]),
        .SHIFT_ERROR(cause[5]), .DIVIDE_ZERO(cause[4]), .MATH_ERROR(cause[3]),
        .ADDRESS_ERROR(cause[2]), .STACK_ERROR(cause[1]), .OSCILLATOR_FAIL(cause[0]),
        .NESTING_DISABLE(traps[5]), .ACC_A_OVERFLOW_TRAP(traps[4]), .ACC_B_OVERFLOW_TRAP(traps[3]),
        .CATASTROPHIC_TRAP(traps[2]), .MATH_TRAP(traps[1]), .IRQ(traps[0]));

    // Free-running system clock, 5 ns period
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single word transfer; the slave's own ready paces both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {16'hA5A5, wd};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Fire causes for one cycle and stop mid-cycle while they are high
    task automatic pulse(input logic [9:0] s);
        @(posedge sys_clk);
        fire <= 1'b1;
        sel <= s;
        @(posedge sys_clk);
        fire <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        #50000;
        error_cnt++;
        results();
    end

    initial begin
        rows = '{'{16'h0700, 10'h200, 16'h4710, 16'h4010}, '{16'h0000, 10'h200, 16'h0000, 16'h0000},
            '{16'h0200, 10'h100, 16'h2210, 16'h2010}, '{16'h0400, 10'h100, 16'h0400, 16'h0000},
            '{16'h0100, 10'h080, 16'h1110, 16'h1010}, '{16'h0100, 10'h040, 16'h0910, 16'h0810},
            '{16'h0000, 10'h080, 16'h0000, 16'h0000}, '{16'h0000, 10'h020, 16'h0090, 16'h0090},
            '{16'h0000, 10'h010, 16'h0050, 16'h0050}, '{16'h0000, 10'h008, 16'h0010, 16'h0010},
            '{16'h0000, 10'h004, 16'h0008, 16'h0008}, '{16'h0000, 10'h002, 16'h0004, 16'h0004},
            '{16'h0000, 10'h001, 16'h0002, 16'h0002}, '{16'h8000, 10'h000, 16'h8000, 16'h0000}};
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        // Each row: set enables, clear status, fire at most one cause, read both registers
        foreach (rows[i]) begin
            bus(1'b1, `TSC_OFF_CTRL, rows[i].en);
            bus(1'b1, `TSC_OFF_IRQ_STAT, 16'hFFFF);
            pulse(rows[i].cause);
            exp_t[3] = rows[i].en[10] & rows[i].cause[9];
            exp_t[2] = rows[i].en[9] & rows[i].cause[8];
            exp_t[1] = rows[i].en[8] & (rows[i].cause[7] | rows[i].cause[6]);
            exp_t[0] = (|rows[i].cause[5:3]) | (|exp_t[3:1]);
            chk("trap outputs", {28'h0, exp_t}, {28'h0, traps[4:1]});
            bus(1'b0, `TSC_OFF_CTRL, 16'h0000);
            chk("control", {16'h0, rows[i].ctrl}, rd);
            bus(1'b0, `TSC_OFF_IRQ_STAT, 16'h0000);
            chk("irq status", {16'h0, rows[i].stat}, rd);
            chk("nesting", {31'h0, rows[i].en[15]}, {31'h0, traps[5]});
            chk("irq masked", 32'h0, {31'h0, traps[0]});
            $display("Row %0d done", i);
        end
        // Software clears a sticky flag by writing zero
        pulse(10'h010);
        bus(1'b1, `TSC_OFF_CTRL, 16'h0000);
        bus(1'b0, `TSC_OFF_CTRL, 16'h0000);
        chk("cleared", 32'h0, rd);
        // Bits 5 and 0 and the upper half read zero
        bus(1'b1, `TSC_OFF_CTRL, 16'hFFFF);
        bus(1'b0, `TSC_OFF_CTRL, 16'h0000);
        chk("all ones", 32'h0000FFDE, rd);
        chk("nesting on", 32'h1, {31'h0, traps[5]});
        bus(1'b1, 8'h0C, 16'hFFFF);
        bus(1'b0, 8'h0C, 16'h0000);
        chk("unmapped", 32'h0, rd);
        chk("okay response", 32'h0, {31'h0, hresp});
        $display("Register access test done");
        // Interrupt: raise, unmask, clear by writing one
        bus(1'b1, `TSC_OFF_CTRL, 16'h0000);
        bus(1'b1, `TSC_OFF_IRQ_STAT, 16'hFFFF);
        pulse(10'h004);
        bus(1'b1, `TSC_OFF_IRQ_MASK, 16'h0008);
        @(negedge sys_clk);
        chk("irq raised", 32'h1, {31'h0, traps[0]});
        bus(1'b0, `TSC_OFF_IRQ_MASK, 16'h0000);
        chk("mask", 32'h8, rd);
        bus(1'b1, `TSC_OFF_IRQ_STAT, 16'h0008);
        @(negedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, traps[0]});
        $display("Interrupt test done");
        // Reset in mid-run wipes every register
        pulse(10'h004);
        bus(1'b1, `TSC_OFF_CTRL, 16'h8700);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            bus(1'b0, 8'(4 * k), 16'h0000);
            chk("after reset", 32'h0, rd);
        end
        chk("irq after reset", 32'h0, {31'h0, traps[0]});
        chk("nesting after reset", 32'h0, {31'h0, traps[5]});
        $display("Reset test done");
        results();
    end
endmodule
`default_nettype wire

// ==== verilog/trap_ahb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "trap_status_map.svh"
// Zero-wait AHB-Lite slave: captures the address phase, gives a write strobe in the data phase
module trap_ahb_slave (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [15:0] wr_data,
    output logic rd_stb,
    output logic [7:0] rd_addr
);
    trap_status_pkg::bus_phase_t phase_ff;
    logic [7:0] addr_ff;

    // Address phase capture; hsize is always a word here
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_ff <= trap_status_pkg::BUS_IDLE;
            addr_ff <= 8'h00;
        end else if (hready) begin
            if (hsel && htrans[1]) begin
                phase_ff <= hwrite ? trap_status_pkg::BUS_WRITE : trap_status_pkg::BUS_READ;
                addr_ff <= haddr[7:0];
            end else begin
                phase_ff <= trap_status_pkg::BUS_IDLE;
            end
        end
    end

    // Never waits, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_stb = (phase_ff == trap_status_pkg::BUS_WRITE);
    assign wr_addr = addr_ff;
    assign wr_data = hwdata[15:0];
    // Read decode uses the live address so hrdata can be registered for the data phase
    assign rd_stb = hready && hsel && htrans[1] && !hwrite && (hsize == 3'h2);
    assign rd_addr = haddr[7:0];
endmodule
`default_nettype wire

// ==== verilog/trap_irq_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "trap_status_map.svh"
// Sticky event status with write-one-to-clear, mask, level interrupt
module trap_irq_ctrl (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [15:0] events,
    input wire logic clr_stb,
    input wire logic [15:0] clr_bits,
    input wire logic mask_stb,
    input wire logic [15:0] mask_data,
    output logic [15:0] stat,
    output logic [15:0] mask,
    output logic irq
);
    logic [15:0] stat_ff;
    logic [15:0] mask_ff;

    // New events win over a clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_ff <= `TSC_IRQ_RESET_VAL;
        end else begin
            stat_ff <= ((clr_stb ? (stat_ff & ~clr_bits) : stat_ff) | events) & `TSC_FLAG_MASK;
        end
    end

    // Mask register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mask_ff <= `TSC_IRQ_RESET_VAL;
        end else if (mask_stb) begin
            mask_ff <= mask_data & `TSC_FLAG_MASK;
        end
    end

    assign stat = stat_ff;
    assign mask = mask_ff;
    assign irq = |(stat_ff & mask_ff);
endmodule
`default_nettype wire

// ==== verilog/trap_status_control.sv ====
// Functional notes
// - Bit 15 one blocks interrupt nesting; zero allows it.
// - Bit 14 flags a trap caused by accumulator A overflow.
// - Bit 13 flags a trap caused by accumulator B overflow.
// - Bits 12 and 11 flag catastrophic overflow traps of A and B.
// - Bits 10 and 9 enable the A and B overflow traps.
// - Bit 8 enables the catastrophic overflow trap for either accumulator.
// - Bit 7 flags a math trap from an invalid accumulator shift.
// - Bit 6 flags a math trap from divide by zero.
// - Bit 3 flags an address error trap.
// - Bit 2 stack error, bit 1 oscillator fail, bit 0 unimplemented.
`timescale 1ns/1ps
`default_nettype none
`include "trap_status_map.svh"
module trap_status_control (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic ACC_A_OVERFLOW,
    input wire logic ACC_B_OVERFLOW,
    input wire logic ACC_A_CATASTROPHIC,
    input wire logic ACC_B_CATASTROPHIC,
    input wire logic SHIFT_ERROR,
    input wire logic DIVIDE_ZERO,
    input wire logic MATH_ERROR,
    input wire logic ADDRESS_ERROR,
    input wire logic STACK_ERROR,
    input wire logic OSCILLATOR_FAIL,
    output logic NESTING_DISABLE,
    output logic ACC_A_OVERFLOW_TRAP,
    output logic ACC_B_OVERFLOW_TRAP,
    output logic CATASTROPHIC_TRAP,
    output logic MATH_TRAP,
    output logic IRQ
);
    logic [15:0] tcs_ff;
    logic [15:0] nxt_tcs;
    logic [15:0] hw_set;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_stb;
    logic [7:0] rd_addr;
    logic [15:0] irq_stat;
    logic [15:0] irq_mask;
    logic trap_a;
    logic trap_b;
    logic trap_cat_a;
    logic trap_cat_b;
    logic ctrl_wr;
    logic stat_clr;
    logic mask_wr;

    // Returns a 16-bit word with one bit set
    function automatic logic [15:0] bit_at(input int pos);
        bit_at = 16'h0001 << pos;
    endfunction

    // Register write decode, shared by the write paths and the checks
    function automatic logic wr_hit(input logic stb, input logic [7:0] addr,
                                    input logic [7:0] off);
        wr_hit = stb && (addr == off);
    endfunction

    trap_ahb_slave u_bus (
        .SYS_CLK(SYS_CLK),
        .ARST_N(ARST_N),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hready(HREADY),
        .hwdata(HWDATA),
        .hreadyout(HREADYOUT),
        .hresp(HRESP),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr)
    );

    // One strobe per register; a single decode keeps logic and checks in step
    assign ctrl_wr = wr_hit(wr_stb, wr_addr, `TSC_OFF_CTRL);
    assign stat_clr = wr_hit(wr_stb, wr_addr, `TSC_OFF_IRQ_STAT);
    assign mask_wr = wr_hit(wr_stb, wr_addr, `TSC_OFF_IRQ_MASK);

    // Trap qualification: an overflow only becomes a trap when its enable is set
    assign trap_a = ACC_A_OVERFLOW && tcs_ff[`TSC_BIT_A_OVF_EN];
    assign trap_b = ACC_B_OVERFLOW && tcs_ff[`TSC_BIT_B_OVF_EN];
    assign trap_cat_a = ACC_A_CATASTROPHIC && tcs_ff[`TSC_BIT_CAT_EN];
    assign trap_cat_b = ACC_B_CATASTROPHIC && tcs_ff[`TSC_BIT_CAT_EN];

    // Hardware set terms; any math cause also raises the summary bit
    always_comb begin
        hw_set = 16'h0000;
        if (trap_a) begin
            hw_set = hw_set | bit_at(`TSC_BIT_ACC_A_OVF);
        end
        if (trap_b) begin
            hw_set = hw_set | bit_at(`TSC_BIT_ACC_B_OVF);
        end
        if (trap_cat_a) begin
            hw_set = hw_set | bit_at(`TSC_BIT_ACC_A_CAT);
        end
        if (trap_cat_b) begin
            hw_set = hw_set | bit_at(`TSC_BIT_ACC_B_CAT);
        end
        if (SHIFT_ERROR) begin
            hw_set = hw_set | bit_at(`TSC_BIT_SHIFT_ERR);
        end
        if (DIVIDE_ZERO) begin
            hw_set = hw_set | bit_at(`TSC_BIT_DIV_ZERO);
        end
        if (MATH_ERROR || SHIFT_ERROR || DIVIDE_ZERO || trap_a || trap_b
            || trap_cat_a || trap_cat_b) begin
            hw_set = hw_set | bit_at(`TSC_BIT_MATH_ERR);
        end
        if (ADDRESS_ERROR) begin
            hw_set = hw_set | bit_at(`TSC_BIT_ADDR_ERR);
        end
        if (STACK_ERROR) begin
            hw_set = hw_set | bit_at(`TSC_BIT_STACK_ERR);
        end
        if (OSCILLATOR_FAIL) begin
            hw_set = hw_set | bit_at(`TSC_BIT_OSC_FAIL);
        end
    end

    // Software write lands first, then hardware sets win; unimplemented bits stay zero
    always_comb begin
        nxt_tcs = tcs_ff;
        if (ctrl_wr) begin
            nxt_tcs = wr_data;
        end
        nxt_tcs = (nxt_tcs | hw_set) & `TSC_IMPL_MASK;
    end

    // Control and status register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tcs_ff <= `TSC_RESET_VAL;
        end else begin
            tcs_ff <= nxt_tcs;
        end
    end

    trap_irq_ctrl u_irq (
        .SYS_CLK(SYS_CLK),
        .ARST_N(ARST_N),
        .events(hw_set),
        .clr_stb(stat_clr),
        .clr_bits(wr_data),
        .mask_stb(mask_wr),
        .mask_data(wr_data),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(IRQ)
    );

    // Read data registered for the data phase; unmapped reads return zero
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HRDATA <= 32'h00000000;
        end else if (rd_stb) begin
            case (rd_addr)
                `TSC_OFF_CTRL: HRDATA <= {16'h0000, tcs_ff};
                `TSC_OFF_IRQ_STAT: HRDATA <= {16'h0000, irq_stat};
                `TSC_OFF_IRQ_MASK: HRDATA <= {16'h0000, irq_mask};
                default: HRDATA <= 32'h00000000;
            endcase
        end
    end

    // Outputs to the core's exception logic
    assign NESTING_DISABLE = tcs_ff[`TSC_BIT_NEST_DIS];
    assign ACC_A_OVERFLOW_TRAP = trap_a;
    assign ACC_B_OVERFLOW_TRAP = trap_b;
    assign CATASTROPHIC_TRAP = trap_cat_a || trap_cat_b;
    assign MATH_TRAP = hw_set[`TSC_BIT_MATH_ERR];

    // A disabled overflow trap never raises its flag
    AST_A_OVF_NEEDS_EN: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (ACC_A_OVERFLOW && !tcs_ff[`TSC_BIT_A_OVF_EN] && !tcs_ff[`TSC_BIT_ACC_A_OVF]
         && !(wr_stb && wr_addr == `TSC_OFF_CTRL)) |=> !tcs_ff[`TSC_BIT_ACC_A_OVF])
        else $error("A overflow flag set while trap disabled");
    AST_B_OVF_SETS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (ACC_B_OVERFLOW && tcs_ff[`TSC_BIT_B_OVF_EN]) |=> tcs_ff[`TSC_BIT_ACC_B_OVF])
        else $error("B overflow trap did not set flag");
    AST_A_OVF_SETS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (ACC_A_OVERFLOW && tcs_ff[`TSC_BIT_A_OVF_EN]) |=> tcs_ff[`TSC_BIT_ACC_A_OVF])
        else $error("A overflow trap did not set flag");
    AST_CAT_GATED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        CATASTROPHIC_TRAP |-> tcs_ff[`TSC_BIT_CAT_EN])
        else $error("Catastrophic trap taken while disabled");
    AST_CAT_FLAG: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        trap_cat_b |=> tcs_ff[`TSC_BIT_ACC_B_CAT] && tcs_ff[`TSC_BIT_MATH_ERR])
        else $error("B catastrophic flag missing");
    AST_DIV_SETS_MATH: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        DIVIDE_ZERO |=> tcs_ff[`TSC_BIT_DIV_ZERO] && tcs_ff[`TSC_BIT_MATH_ERR])
        else $error("Divide by zero not recorded");
    AST_SHIFT_SETS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        SHIFT_ERROR |=> tcs_ff[`TSC_BIT_SHIFT_ERR])
        else $error("Shift error not recorded");
    AST_MATH_SETS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        MATH_ERROR |=> tcs_ff[`TSC_BIT_MATH_ERR])
        else $error("Math error not recorded");
    AST_ADDR_SETS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ADDRESS_ERROR |=> tcs_ff[`TSC_BIT_ADDR_ERR])
        else $error("Address error not recorded");
    AST_UNIMPL_ZERO: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (tcs_ff[0] == 1'b0) && (tcs_ff[5] == 1'b0))
        else $error("Unimplemented control bits hold a one");
    AST_STACK_SETS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        STACK_ERROR |=> tcs_ff[`TSC_BIT_STACK_ERR])
        else $error("Stack error not recorded");
    AST_STICKY: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (tcs_ff[`TSC_BIT_OSC_FAIL] && !(wr_stb && wr_addr == `TSC_OFF_CTRL))
        |=> tcs_ff[`TSC_BIT_OSC_FAIL])
        else $error("Oscillator fail flag dropped without a write");
    AST_NEST_OUT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (wr_stb && wr_addr == `TSC_OFF_CTRL) |=> NESTING_DISABLE == $past(wr_data[15]))
        else $error("Nesting disable does not follow write");

    // Disabled traps leave their flags alone; only a software write may set them then
    AST_B_OVF_NEEDS_EN: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (ACC_B_OVERFLOW && !tcs_ff[`TSC_BIT_B_OVF_EN] && !tcs_ff[`TSC_BIT_ACC_B_OVF]
         && !ctrl_wr) |=> !tcs_ff[`TSC_BIT_ACC_B_OVF])
        else $error("B overflow flag set while trap disabled");
    AST_A_CAT_NEEDS_EN: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (ACC_A_CATASTROPHIC && !tcs_ff[`TSC_BIT_CAT_EN] && !tcs_ff[`TSC_BIT_ACC_A_CAT]
         && !ctrl_wr) |=> !tcs_ff[`TSC_BIT_ACC_A_CAT])
        else $error("A catastrophic flag set while trap disabled");
    AST_B_CAT_NEEDS_EN: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (ACC_B_CATASTROPHIC && !tcs_ff[`TSC_BIT_CAT_EN] && !tcs_ff[`TSC_BIT_ACC_B_CAT]
         && !ctrl_wr) |=> !tcs_ff[`TSC_BIT_ACC_B_CAT])
        else $error("B catastrophic flag set while trap disabled");
    AST_A_CAT_FLAG: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        trap_cat_a |=> tcs_ff[`TSC_BIT_ACC_A_CAT] && tcs_ff[`TSC_BIT_MATH_ERR])
        else $error("A catastrophic flag missing");
    AST_A_OVF_OUT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ACC_A_OVERFLOW_TRAP |-> tcs_ff[`TSC_BIT_A_OVF_EN])
        else $error("A overflow trap taken while disabled");
    AST_B_OVF_OUT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ACC_B_OVERFLOW_TRAP |-> tcs_ff[`TSC_BIT_B_OVF_EN])
        else $error("B overflow trap taken while disabled");

    // Status bits stay at zero with no cause; catches a crossed or stuck set term
    AST_A_OVF_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!trap_a && !tcs_ff[`TSC_BIT_ACC_A_OVF] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_ACC_A_OVF])
        else $error("A overflow flag set with no trap");
    AST_B_OVF_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!trap_b && !tcs_ff[`TSC_BIT_ACC_B_OVF] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_ACC_B_OVF])
        else $error("B overflow flag set with no trap");
    AST_SHIFT_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!SHIFT_ERROR && !tcs_ff[`TSC_BIT_SHIFT_ERR] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_SHIFT_ERR])
        else $error("Shift error flag set with no cause");
    AST_DIV_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!DIVIDE_ZERO && !tcs_ff[`TSC_BIT_DIV_ZERO] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_DIV_ZERO])
        else $error("Divide by zero flag set with no cause");
    AST_MATH_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!MATH_TRAP && !tcs_ff[`TSC_BIT_MATH_ERR] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_MATH_ERR])
        else $error("Math error flag set with no math trap");
    AST_ADDR_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!ADDRESS_ERROR && !tcs_ff[`TSC_BIT_ADDR_ERR] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_ADDR_ERR])
        else $error("Address error flag set with no cause");
    AST_STACK_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!STACK_ERROR && !tcs_ff[`TSC_BIT_STACK_ERR] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_STACK_ERR])
        else $error("Stack error flag set with no cause");
    AST_OSC_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!OSCILLATOR_FAIL && !tcs_ff[`TSC_BIT_OSC_FAIL] && !ctrl_wr)
        |=> !tcs_ff[`TSC_BIT_OSC_FAIL])
        else $error("Oscillator fail flag set with no cause");

    // Software owns the flags: a written zero clears them unless the cause is live
    AST_FLAG_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (ctrl_wr && !wr_data[`TSC_BIT_OSC_FAIL] && !OSCILLATOR_FAIL)
        |=> !tcs_ff[`TSC_BIT_OSC_FAIL])
        else $error("Oscillator fail flag survived a written zero");
    AST_ADDR_STICKY: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (tcs_ff[`TSC_BIT_ADDR_ERR] && !ctrl_wr) |=> tcs_ff[`TSC_BIT_ADDR_ERR])
        else $error("Address error flag dropped without a write");
    AST_IRQ_STICKY: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (irq_stat[`TSC_BIT_ADDR_ERR] && !stat_clr) |=> irq_stat[`TSC_BIT_ADDR_ERR])
        else $error("Address error interrupt status dropped without a clear");
    AST_OSC_SETS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        OSCILLATOR_FAIL |=> tcs_ff[`TSC_BIT_OSC_FAIL])
        else $error("Oscillator fail not recorded");

    // Nesting control moves only through a register write, never through a cause
    AST_NEST_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !ctrl_wr |=> $stable(NESTING_DISABLE))
        else $error("Nesting disable changed without a write");
    AST_DIV_IRQ_STAT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        DIVIDE_ZERO |=> irq_stat[`TSC_BIT_DIV_ZERO])
        else $error("Divide by zero missing from interrupt status");
endmodule
`default_nettype wire
